// ---- scb_defines.vh ----
// constants for the smbus clock buffer control block
`ifndef SCB_DEFINES_VH
`define SCB_DEFINES_VH
`define SCB_ADDR 7'h6C
`define SCB_IDX_MODE 8'h00
`define SCB_IDX_GATE_LO 8'h01
`define SCB_IDX_GATE_HI 8'h02
`define SCB_IDX_RSVD3 8'h03
`define SCB_IDX_RSVD4 8'h04
`define SCB_IDX_VENDOR 8'h05
`define SCB_IDX_DEVICE 8'h06
`define SCB_IDX_COUNT 8'h07
`define SCB_IDX_RSVD8 8'h08
`define SCB_MODE_HI 7
`define SCB_MODE_LO 6
`define SCB_SWEN_BIT 3
`define SCB_SWMODE_HI 2
`define SCB_SWMODE_LO 1
`define SCB_FREQ_BIT 0
`define SCB_SWEN_RST 1'h0
`define SCB_SWMODE_RST 2'h3
`define SCB_GATE_RST 8'hFF
`define SCB_GATE_LO_RSVD 8'h09
`define SCB_GATE_HI_RSVD 8'h08
`define SCB_COUNT_RST 5'h08
`define SCB_STRAP_SETTLE 2'h3
`endif

// ---- scb_host_model.sv ----
// smbus host model: drives scl and pulls sda low
`timescale 1ns/1ps
module scb_host_model (
   // smbus wires
   input wire sda_i,
   output logic scl_o,
   output logic sda_oe_o
);
   initial begin
      scl_o = 1'b1;
      sda_oe_o = 1'b0;
   end
   // start or repeated start
   task st;
      sda_oe_o = 1'b0;
      #20 scl_o = 1'b1;
      #20 sda_oe_o = 1'b1;
      #20 scl_o = 1'b0;
      #20;
   endtask
   // stop, scl then idles high
   task sp;
      sda_oe_o = 1'b1;
      #20 scl_o = 1'b1;
      #20 sda_oe_o = 1'b0;
      #40;
   endtask
   // eight bits msb first, then ack bit m out or a
   task xfer(input logic [7:0] w, input logic m,
      output logic [7:0] r, output logic a);
      for (int i = 8; i >= 0; i--) begin
         sda_oe_o = (i > 0) ? !w[i-1] : !m;
         #20 scl_o = 1'b1;
         #20 if (i > 0) r[i-1] = sda_i; else a = sda_i;
         #20 scl_o = 1'b0;
         #20;
      end
   endtask
endmodule

// ---- scb_smbus_ctrl.v ----
// smbus target and control register bank of the clock buffer
// Functional notes
// - target acks its write address, the index byte and the count byte.
// - each write data byte is acked; only the first count bytes are stored, at incrementing indices.
// - after read address ack, send count byte, then bytes in ascending index.
// - index 0 bits 7:6 read back the strap-latched pll mode.
// - index 0 bit 3 picks pll mode source: strap or software; resets 0.
// - index 0 bits 2:1 are software pll mode bits, default 3, when enabled.
// - mode readback keeps the strap value despite software override.
// - index 0 bit 0 reads the latched frequency strap: 0 133MHz, 1 100MHz.
// - index 1 bits 7,6,5,4,2,1 gate outputs 5..0; 0 forces low, default 1.
// - index 2 bit 2 gates output 7, bit 0 output 6; default 1.
// - index 7 five-bit count, default 8, is the first read byte; the host nack, not the count, ends a read.
// - index 5 holds revision and maker codes, index 6 a device code.
`timescale 1ns/1ps
`include "scb_defines.vh"
module scb_smbus_ctrl #(
   parameter [3:0] REV_CODE = 4'h0,    // arbitrary value
   parameter [3:0] MAKER_CODE = 4'h3,  // arbitrary value
   parameter [7:0] DEVICE_CODE = 8'h5A // arbitrary value
) (
   // clock and reset
   input wire clk_i,
   input wire rst_b_i,
   // smbus pins
   input wire scl_i,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   // straps and warm reset
   input wire [1:0] pll_bandwidth_strap_i,
   input wire freq_select_strap_i,
   input wire warm_rst_b_i,
   // controls to the clock path
   output reg [1:0] pll_mode_o,
   output reg [7:0] out_gate_o
);
   // protocol states
   localparam [3:0] ST_IDLE = 4'h0;
   localparam [3:0] ST_ADDR = 4'h1;
   localparam [3:0] ST_ADDR_ACK = 4'h2;
   localparam [3:0] ST_RX = 4'h3;
   localparam [3:0] ST_RX_ACK = 4'h4;
   localparam [3:0] ST_TX = 4'h5;
   localparam [3:0] ST_TX_ACK = 4'h6;
   localparam [3:0] ST_WAIT = 4'h7;

   // synchronisers
   reg [1:0] scl_s_q, sda_s_q, warm_s_q, freq_s_q;
   reg [1:0] bw0_s_q, bw1_s_q;
   reg scl_q, sda_q;
   // straps
   reg [1:0] settle_q;
   reg strap_done_q;
   reg [1:0] strap_mode_q;
   reg strap_freq_q;
   // registers
   reg swen_q;
   reg [1:0] swmode_q;
   reg [7:0] gate_lo_q, gate_hi_q;
   reg [4:0] count_q;
   // protocol
   reg [3:0] state_q;
   reg [7:0] sh_q;
   reg [3:0] bit_q;
   reg [1:0] phase_q;
   reg [7:0] index_q;
   reg [7:0] left_q;
   reg rd_ack_q;

   // pin edges and bus conditions, from synchronised levels only
   wire scl_rise = scl_s_q[1] & ~scl_q;
   wire scl_fall = ~scl_s_q[1] & scl_q;
   wire start_det = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
   wire stop_det = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

   // register read decode
   function [7:0] rd_byte;
      input [7:0] idx;
      begin
         case (idx)
            `SCB_IDX_MODE: rd_byte = {strap_mode_q, 2'h0, swen_q,
               swmode_q, strap_freq_q};
            `SCB_IDX_GATE_LO: rd_byte = gate_lo_q;
            `SCB_IDX_GATE_HI: rd_byte = gate_hi_q;
            `SCB_IDX_VENDOR: rd_byte = {REV_CODE, MAKER_CODE};
            `SCB_IDX_DEVICE: rd_byte = DEVICE_CODE;
            `SCB_IDX_COUNT: rd_byte = {3'h0, count_q};
            default: rd_byte = 8'h00;
         endcase
      end
   endfunction

   // next register byte on a read, decoded once for data and drive
   wire [7:0] rd_next = rd_byte(index_q);

   // pin synchronisers
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         warm_s_q <= 2'h3;
         freq_s_q <= 2'h0;
         bw0_s_q <= 2'h0;
         bw1_s_q <= 2'h0;
         scl_q <= 1'h1;
         sda_q <= 1'h1;
      end else begin
         scl_s_q <= {scl_s_q[0], scl_i};
         sda_s_q <= {sda_s_q[0], sda_i};
         warm_s_q <= {warm_s_q[0], warm_rst_b_i};
         freq_s_q <= {freq_s_q[0], freq_select_strap_i};
         bw0_s_q <= {bw0_s_q[0], pll_bandwidth_strap_i[0]};
         bw1_s_q <= {bw1_s_q[0], pll_bandwidth_strap_i[1]};
         scl_q <= scl_s_q[1];
         sda_q <= sda_s_q[1];
      end
   end

   // strap latch and applied pll mode
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         settle_q <= 2'h0;
         strap_done_q <= 1'h0;
         strap_mode_q <= 2'h0;
         strap_freq_q <= 1'h0;
         pll_mode_o <= 2'h0;
         out_gate_o <= 8'hFF;
      end else begin
         if (!strap_done_q) begin
            if (settle_q == `SCB_STRAP_SETTLE) begin
               strap_done_q <= 1'h1;
               strap_mode_q <= {bw1_s_q[1], bw0_s_q[1]};
               strap_freq_q <= freq_s_q[1];
               pll_mode_o <= {bw1_s_q[1], bw0_s_q[1]};
            end else begin
               settle_q <= settle_q + 2'h1;
            end
         end else if (!warm_s_q[1]) begin
            pll_mode_o <= swen_q ? swmode_q : strap_mode_q;
         end
         out_gate_o <= {gate_hi_q[2], gate_hi_q[0], gate_lo_q[7:4],
            gate_lo_q[2:1]};
      end
   end

   // smbus target
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= ST_IDLE;
         sh_q <= 8'h00;
         bit_q <= 4'h0;
         phase_q <= 2'h0;
         index_q <= 8'h00;
         left_q <= 8'h00;
         rd_ack_q <= 1'h0;
         sda_o <= 1'h0;
         sda_oe_o <= 1'h0;
         swen_q <= `SCB_SWEN_RST;
         swmode_q <= `SCB_SWMODE_RST;
         gate_lo_q <= `SCB_GATE_RST;
         gate_hi_q <= `SCB_GATE_RST & ~8'hF2;
         count_q <= `SCB_COUNT_RST;
      end else if (stop_det) begin
         state_q <= ST_IDLE;
         sda_oe_o <= 1'h0;
      end else if (start_det) begin
         state_q <= ST_ADDR;
         bit_q <= 4'h0;
         sda_oe_o <= 1'h0;
      end else begin
         case (state_q)
            ST_ADDR, ST_RX: begin
               // shift in one bit per scl rise, msb first
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_q};
                  bit_q <= bit_q + 4'h1;
               end else if (scl_fall && bit_q == 4'h8) begin
                  if (state_q == ST_ADDR) begin
                     if (sh_q[7:1] == `SCB_ADDR) begin
                        sda_oe_o <= 1'h1;
                        state_q <= ST_ADDR_ACK;
                        if (!sh_q[0]) begin
                           phase_q <= 2'h0;
                        end
                     end else begin
                        state_q <= ST_WAIT;
                     end
                  end else begin
                     // first byte is the index, second the count
                     sda_oe_o <= 1'h1;
                     state_q <= ST_RX_ACK;
                     if (phase_q == 2'h0) begin
                        index_q <= sh_q;
                        phase_q <= 2'h1;
                     end else if (phase_q == 2'h1) begin
                        left_q <= sh_q;
                        phase_q <= 2'h2;
                     end else if (left_q != 8'h00) begin
                        left_q <= left_q - 8'h01;
                        index_q <= index_q + 8'h01;
                        case (index_q)
                           `SCB_IDX_MODE: begin
                              swen_q <= sh_q[`SCB_SWEN_BIT];
                              swmode_q <= sh_q[`SCB_SWMODE_HI:
                                 `SCB_SWMODE_LO];
                           end
                           `SCB_IDX_GATE_LO:
                              gate_lo_q <= (sh_q & 8'hF6) |
                                 `SCB_GATE_LO_RSVD;
                           `SCB_IDX_GATE_HI:
                              gate_hi_q <= (sh_q & 8'h05) |
                                 `SCB_GATE_HI_RSVD;
                           `SCB_IDX_COUNT: count_q <= sh_q[4:0];
                           default: ;
                        endcase
                     end
                  end
               end
            end

            // end of address ack: read sends the count byte first
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  bit_q <= 4'h0;
                  if (sh_q[0]) begin
                     sh_q <= {3'h0, count_q};
                     // count byte msb is always zero, so pull low
                     sda_oe_o <= 1'h1;
                     state_q <= ST_TX;
                  end else begin
                     sda_oe_o <= 1'h0;
                     state_q <= ST_RX;
                  end
               end
            end

            // release the ack and take the next byte
            ST_RX_ACK: begin
               if (scl_fall) begin
                  bit_q <= 4'h0;
                  sda_oe_o <= 1'h0;
                  state_q <= ST_RX;
               end
            end

            // drive one bit per scl fall, release for the host ack
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_q == 4'h7) begin
                     sda_oe_o <= 1'h0;
                     state_q <= ST_TX_ACK;
                  end else begin
                     sh_q <= {sh_q[6:0], 1'h0};
                     sda_oe_o <= ~sh_q[6];
                     bit_q <= bit_q + 4'h1;
                  end
               end
            end

            // host ack continues with the next index, nack ends
            ST_TX_ACK: begin
               if (scl_rise) begin
                  rd_ack_q <= ~sda_q;
               end else if (scl_fall) begin
                  if (rd_ack_q) begin
                     sh_q <= rd_next;
                     sda_oe_o <= ~rd_next[7];
                     index_q <= index_q + 8'h01;
                     bit_q <= 4'h0;
                     state_q <= ST_TX;
                  end else begin
                     state_q <= ST_WAIT;
                  end
               end
            end

            // not addressed or done: stay off the bus until start or stop
            ST_WAIT: begin
               sda_oe_o <= 1'h0;
            end

            // idle and unused codes keep the bus released
            default: begin
               state_q <= ST_IDLE;
               sda_oe_o <= 1'h0;
            end
         endcase
      end
   end
endmodule

// ---- scb_smbus_ctrl_bench.sv ----
// bench for the smbus clock buffer control block
`timescale 1ns/1ps
`include "scb_defines.vh"
module scb_smbus_ctrl_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic warm_b = 1'b1;
   logic [1:0] bw_strap = 2'h1;
   logic fs_strap = 1'b1;
   logic scl, h_oe, sda_oe, sda_o, a;
   wire sda = !(h_oe || sda_oe);
   logic [1:0] pll_mode;
   logic [7:0] gate, junk, rb [0:9], wd [0:7];
   logic [7:0] exp0 [0:9] = '{8'h08, 8'h47, 8'hFF, 8'h0D, 8'h00,
      8'h00, 8'h03, 8'h5A, 8'h08, 8'h00};
   logic [7:0] exp1 [0:6] = '{8'h03, 8'h08, 8'h00, 8'h00, 8'h03,
      8'h5A, 8'h03};
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   scb_host_model host (.sda_i(sda), .scl_o(scl), .sda_oe_o(h_oe));
   scb_smbus_ctrl dut (.clk_i(clk), .rst_b_i(rst_b), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .pll_bandwidth_strap_i(bw_strap), .freq_select_strap_i(fs_strap),
      .warm_rst_b_i(warm_b), .pll_mode_o(pll_mode), .out_gate_o(gate));
   initial begin
      forever #5 clk = !clk;
   end
   task report_and_stop;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop;
      end
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task hdr(input logic [7:0] idx);
      host.st;
      host.xfer({`SCB_ADDR, 1'b0}, 1'b1, junk, a);
      chk({7'h0, a}, 8'h00);
      host.xfer(idx, 1'b1, junk, a);
      chk({7'h0, a}, 8'h00);
   endtask
   task wr(input logic [7:0] idx, input logic [7:0] cnt, input int n);
      hdr(idx);
      host.xfer(cnt, 1'b1, junk, a);
      chk({7'h0, a}, 8'h00);
      for (int i = 0; i < n; i++) begin
         host.xfer(wd[i], 1'b1, junk, a);
         chk({7'h0, a}, 8'h00);
      end
      host.sp;
   endtask
   task rd(input logic [7:0] idx, input int n);
      hdr(idx);
      host.st;
      host.xfer({`SCB_ADDR, 1'b1}, 1'b1, junk, a);
      chk({7'h0, a}, 8'h00);
      for (int i = 0; i <= n; i++) host.xfer(8'hFF, i == n, rb[i], a);
      host.sp;
   endtask
   initial begin
      wd = '{8'hF8, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      rd(8'h00, 9);
      for (int i = 0; i < 10; i++) chk(rb[i], exp0[i]);
      wr(8'h00, 8'h02, 3);
      rd(8'h00, 3);
      chk(rb[1], 8'h49);
      chk(rb[2], 8'h09);
      chk(rb[3], 8'h0D);
      chk(gate, 8'hC0);
      chk({6'h0, pll_mode}, 8'h01);
      @(posedge clk) #1 warm_b = 1'b0;
      repeat (10) @(posedge clk);
      #1 warm_b = 1'b1;
      repeat (10) @(posedge clk);
      #1;
      chk({6'h0, pll_mode}, 8'h00);
      wd = '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03, 8'h00, 8'h00};
      wr(8'h02, 8'h06, 6);
      chk(gate, 8'h00);
      rd(8'h02, 6);
      for (int i = 0; i < 7; i++) chk(rb[i], exp1[i]);
      host.st;
      host.xfer(8'hAA, 1'b1, junk, a);
      chk({7'h0, a}, 8'h01);
      host.sp;
      @(posedge clk) #1 rst_b = 1'b0;
      bw_strap = 2'h3;
      fs_strap = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      chk(gate, 8'hFF);
      chk({6'h0, pll_mode}, 8'h03);
      rd(8'h00, 1);
      chk(rb[0], 8'h08);
      chk(rb[1], 8'hC6);
      report_and_stop;
   end
endmodule

// ---- scb_smbus_ctrl_checker.sv ----
// port assertions for the smbus control block
`timescale 1ns/1ps
module scb_smbus_ctrl_checker (
   // clock, reset and pins
   input wire clk_i,
   input wire rst_b_i,
   input wire scl_i,
   input wire sda_o,
   input wire sda_oe_o,
   // straps and controls
   input wire [1:0] pll_bandwidth_strap_i,
   input wire warm_rst_b_i,
   input wire [1:0] pll_mode_o,
   input wire [7:0] out_gate_o
);
   reg [3:0] since_q;
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) since_q <= 4'h0;
      else if (!warm_rst_b_i) since_q <= 4'h0;
      else if (since_q != 4'hF) since_q <= since_q + 4'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   a_drive_low_only: assert property (sda_o == 1'b0)
      else $error("sda value high");
   a_reset_values: assert property ($rose(rst_b_i) |->
      !sda_oe_o && out_gate_o == 8'hFF && pll_mode_o == 2'h0)
      else $error("bad reset values");
   a_strap_mode_seen: assert property ($rose(rst_b_i) |->
      ##[1:12] pll_mode_o == pll_bandwidth_strap_i)
      else $error("strap mode not applied");
   a_ack_rise_low: assert property ($rose(sda_oe_o) |->
      !scl_i && $past(scl_i) == 1'b0)
      else $error("sda pull began with scl high");
   a_ack_fall_low: assert property ($fell(sda_oe_o) |-> !scl_i)
      else $error("sda release with scl high");
   a_hold_scl_high: assert property (
      scl_i && $past(scl_i) |-> $stable(sda_oe_o))
      else $error("sda moved while scl high");
   a_pull_bounded: assert property (
      $rose(sda_oe_o) |-> ##[1:100] !sda_oe_o)
      else $error("sda held low too long");
   a_mode_warm_only: assert property (
      $changed(pll_mode_o) |-> since_q < 4'hA)
      else $error("pll mode moved without warm reset");
endmodule
bind scb_smbus_ctrl scb_smbus_ctrl_checker chk (.clk_i(clk_i),
   .rst_b_i(rst_b_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .pll_bandwidth_strap_i(pll_bandwidth_strap_i),
   .warm_rst_b_i(warm_rst_b_i), .pll_mode_o(pll_mode_o),
   .out_gate_o(out_gate_o));
